// File: core/prx_defines.vh
// register offsets, field layouts, reset values and timing counts for the proximity unit
// assumes inclusion by the design files only; definitions only
`ifndef PRX_DEFINES_VH
`define PRX_DEFINES_VH

// register byte offsets
`define PRX_CTRL_OFS 12'h000
`define PRX_TUNE_OFS 12'h004
`define PRX_FILT_OFS 12'h008
`define PRX_COMP_OFS 12'h00C
`define PRX_STAT_OFS 12'h010
`define PRX_RAW_OFS 12'h014
`define PRX_USEFUL_OFS 12'h018
`define PRX_AVG_OFS 12'h01C
`define PRX_DIFF_OFS 12'h020
`define PRX_CMD_OFS 12'h024

// control fields
`define PRX_SCAN_LSB 0
`define PRX_SCAN_MSB 15
`define PRX_SENSOR_BIT 16
`define PRX_SHIELD_BIT 17
`define PRX_BOOST_BIT 18
`define PRX_HIGHIM_BIT 19
// tuning fields
`define PRX_GAIN_LSB 0
`define PRX_GAIN_MSB 3
`define PRX_FREQ_LSB 4
`define PRX_FREQ_MSB 7
// filter fields
`define PRX_RAWF_LSB 0
`define PRX_RAWF_MSB 3
`define PRX_AVGF_LSB 4
`define PRX_AVGF_MSB 7
`define PRX_THR_LSB 16
`define PRX_THR_MSB 27
// compensation fields
`define PRX_DRIFT_LSB 0
`define PRX_DRIFT_MSB 11
`define PRX_CPRD_LSB 12
`define PRX_CPRD_MSB 19
`define PRX_STUCK_LSB 20
`define PRX_STUCK_MSB 27
// status fields
`define PRX_STAT_NEAR_BIT 0
`define PRX_STAT_COMP_BIT 1
`define PRX_STAT_BUSY_BIT 2
// command fields
`define PRX_CMD_COMP_BIT 0

// reset values
`define PRX_CTRL_RST 32'h00000000
`define PRX_TUNE_RST 32'h00000000
`define PRX_FILT_RST 32'h01000044
`define PRX_COMP_RST 32'h00000000

// timing: scan period unit in microseconds at a 50 MHz clock
`define PRX_CLK_MHZ 50
`define PRX_SCAN_UNIT_US 100
`define PRX_SCAN_UNIT_CYC (`PRX_SCAN_UNIT_US * `PRX_CLK_MHZ)

`endif

// File: core/prx_lowpass.v
// first-order low-pass step: out = (1-k/16)*in_new + (k/16)*prev
// assumes combinational use by the sequencer, coefficient in sixteenths
`timescale 1ns/1ps

module prx_lowpass #(
    parameter W = 12
) (
    input wire [W-1:0] prev_val,
    input wire [W-1:0] new_val,
    input wire [3:0] coeff,
    output wire [W-1:0] out_val
);

    wire [W+4:0] weighted;

    assign weighted = prev_val * coeff + new_val * (5'h10 - {1'b0, coeff});
    assign out_val = weighted[W+3:4];

endmodule // prx_lowpass

// File: core/prx_proximity.v
// proximity sensing digital processing with apb register slave
// assumes one clock core_clk at 50 MHz; converter handshake shared with touch path
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "prx_defines.vh"

module prx_proximity #(
    parameter SCAN_UNIT_CYC = `PRX_SCAN_UNIT_CYC
) (
    input wire core_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg adc_req,
    input wire adc_grant,
    input wire adc_done,
    input wire [11:0] adc_data,
    output reg afe_comp_start,
    input wire afe_comp_done,
    output reg sensor_pin_select,
    output reg shield_pin_select,
    output reg gain_boost_option,
    output reg high_immunity_option,
    output reg [3:0] sense_gain_setting,
    output reg [3:0] sense_frequency_setting,
    output reg near_flag
);

    // ****************************************
    // states and helpers
    // ****************************************
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_COMP = 3'h1;
    localparam [2:0] ST_CONV = 3'h2;
    localparam [2:0] ST_USEF = 3'h3;
    localparam [2:0] ST_AVG = 3'h4;
    localparam [2:0] ST_DIFF = 3'h5;
    localparam [2:0] ST_FLAG = 3'h6;

    function [11:0] absdiff;
        input [11:0] a;
        input [11:0] b;
        begin
            absdiff = (a > b) ? (a - b) : (b - a);
        end
    endfunction

    reg [31:0] ctrl_q;
    reg [31:0] tune_q;
    reg [31:0] filt_q;
    reg [31:0] comp_q;
    reg [2:0] state_q;
    reg [15:0] unit_cnt_q;
    reg [15:0] period_cnt_q;
    reg tick_q;
    reg [11:0] raw_cap_sample;
    reg [11:0] filtered_cap_value;
    reg [11:0] environment_average;
    reg [12:0] user_cap_difference;
    reg [11:0] avg_at_comp_q;
    reg comp_pending_status;
    reg comp_active_q;
    reg first_sample_q;
    reg [7:0] comp_prd_cnt_q;
    reg [7:0] stuck_cnt_q;
    reg host_comp_q;

    wire [15:0] scan_period_setting;
    wire [3:0] raw_filter_coeff;
    wire [3:0] avg_coeff;
    wire [11:0] near_threshold;
    wire [11:0] drift_level;
    wire [7:0] periodic_comp_rate;
    wire [7:0] stuck_near_limit;
    wire [11:0] useful_next;
    wire [11:0] avg_next;
    wire enabled;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire drift_req;
    wire prd_req;
    wire stuck_req;
    wire start_req;

    assign scan_period_setting = ctrl_q[`PRX_SCAN_MSB:`PRX_SCAN_LSB];
    assign raw_filter_coeff = filt_q[`PRX_RAWF_MSB:`PRX_RAWF_LSB];
    assign avg_coeff = filt_q[`PRX_AVGF_MSB:`PRX_AVGF_LSB];
    assign near_threshold = filt_q[`PRX_THR_MSB:`PRX_THR_LSB];
    assign drift_level = comp_q[`PRX_DRIFT_MSB:`PRX_DRIFT_LSB];
    assign periodic_comp_rate = comp_q[`PRX_CPRD_MSB:`PRX_CPRD_LSB];
    assign stuck_near_limit = comp_q[`PRX_STUCK_MSB:`PRX_STUCK_LSB];
    assign enabled = (scan_period_setting != 16'h0000);

    // ****************************************
    // apb slave, zero wait states
    // ****************************************
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_en = psel & ~penable;
    assign addr_ok = (paddr <= `PRX_CMD_OFS) && (paddr[1:0] == 2'h0);
    // enabling the scan period raises a request
    assign start_req = wr_en && (paddr == `PRX_CTRL_OFS) && !enabled
        && (pwdata[`PRX_SCAN_MSB:`PRX_SCAN_LSB] != 16'h0000);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `PRX_CTRL_RST;
            tune_q <= `PRX_TUNE_RST;
            filt_q <= `PRX_FILT_RST;
            comp_q <= `PRX_COMP_RST;
            host_comp_q <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            host_comp_q <= 1'b0;
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (wr_en && !pslverr) begin
                case (paddr)
                    `PRX_CTRL_OFS: ctrl_q <= {12'h000, pwdata[19:0]};
                    `PRX_TUNE_OFS: tune_q <= {24'h000000, pwdata[7:0]};
                    `PRX_FILT_OFS: filt_q <= {4'h0, pwdata[27:16], 8'h00, pwdata[7:0]};
                    `PRX_COMP_OFS: comp_q <= {4'h0, pwdata[27:0]};
                    `PRX_CMD_OFS: host_comp_q <= pwdata[`PRX_CMD_COMP_BIT];
                    default: host_comp_q <= 1'b0;
                endcase
            end
            if (rd_en) begin
                case (pwrite ? 12'hFFF : paddr)
                    `PRX_CTRL_OFS: prdata <= ctrl_q;
                    `PRX_TUNE_OFS: prdata <= tune_q;
                    `PRX_FILT_OFS: prdata <= filt_q;
                    `PRX_COMP_OFS: prdata <= comp_q;
                    `PRX_STAT_OFS: prdata <= {29'h0, (state_q != ST_IDLE),
                        comp_pending_status, near_flag};
                    `PRX_RAW_OFS: prdata <= {20'h0, raw_cap_sample};
                    `PRX_USEFUL_OFS: prdata <= {20'h0, filtered_cap_value};
                    `PRX_AVG_OFS: prdata <= {20'h0, environment_average};
                    `PRX_DIFF_OFS: prdata <= {{19{user_cap_difference[12]}},
                        user_cap_difference};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // front-end configuration outputs
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sensor_pin_select <= 1'b0;
            shield_pin_select <= 1'b0;
            gain_boost_option <= 1'b0;
            high_immunity_option <= 1'b0;
            sense_gain_setting <= 4'h0;
            sense_frequency_setting <= 4'h0;
        end else begin
            sensor_pin_select <= ctrl_q[`PRX_SENSOR_BIT];
            shield_pin_select <= ctrl_q[`PRX_SHIELD_BIT];
            gain_boost_option <= ctrl_q[`PRX_BOOST_BIT];
            high_immunity_option <= ctrl_q[`PRX_HIGHIM_BIT];
            sense_gain_setting <= tune_q[`PRX_GAIN_MSB:`PRX_GAIN_LSB];
            sense_frequency_setting <= tune_q[`PRX_FREQ_MSB:`PRX_FREQ_LSB];
        end
    end

    // ****************************************
    // scan period timer
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            unit_cnt_q <= 16'h0000;
            period_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (!enabled) begin
                unit_cnt_q <= 16'h0000;
                period_cnt_q <= 16'h0000;
            end else if (unit_cnt_q == SCAN_UNIT_CYC[15:0] - 16'h0001) begin
                unit_cnt_q <= 16'h0000;
                if (period_cnt_q >= scan_period_setting - 16'h0001) begin
                    period_cnt_q <= 16'h0000;
                    tick_q <= 1'b1;
                end else begin
                    period_cnt_q <= period_cnt_q + 16'h0001;
                end
            end else begin
                unit_cnt_q <= unit_cnt_q + 16'h0001;
            end
        end
    end

    // ****************************************
    // processing chain
    // ****************************************
    prx_lowpass #(.W(12)) u_useful (
        .prev_val(filtered_cap_value),
        .new_val(raw_cap_sample),
        .coeff(raw_filter_coeff),
        .out_val(useful_next)
    );

    prx_lowpass #(.W(12)) u_avg (
        .prev_val(environment_average),
        .new_val(filtered_cap_value),
        .coeff(avg_coeff),
        .out_val(avg_next)
    );

    assign drift_req = (state_q == ST_AVG) && !first_sample_q && (drift_level != 12'h000)
        && (absdiff(environment_average, avg_at_comp_q) > drift_level);
    assign prd_req = (state_q == ST_FLAG) && (periodic_comp_rate != 8'h00)
        && (comp_prd_cnt_q >= periodic_comp_rate - 8'h01);
    assign stuck_req = (state_q == ST_FLAG) && (stuck_near_limit != 8'h00)
        && near_flag && (stuck_cnt_q >= stuck_near_limit - 8'h01);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            adc_req <= 1'b0;
            afe_comp_start <= 1'b0;
            near_flag <= 1'b0;
            raw_cap_sample <= 12'h000;
            filtered_cap_value <= 12'h000;
            environment_average <= 12'h000;
            user_cap_difference <= 13'h0000;
            avg_at_comp_q <= 12'h000;
            comp_pending_status <= 1'b0;
            comp_active_q <= 1'b0;
            first_sample_q <= 1'b1;
            comp_prd_cnt_q <= 8'h00;
            stuck_cnt_q <= 8'h00;
        end else begin
            afe_comp_start <= 1'b0;
            // any source sets; merged into one pending flag
            if (start_req || host_comp_q || drift_req || prd_req || stuck_req) begin
                comp_pending_status <= 1'b1;
            end else if (comp_active_q && afe_comp_done) begin
                comp_pending_status <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (!enabled) begin
                        first_sample_q <= 1'b1;
                    end else if (tick_q) begin
                        if (comp_pending_status) begin
                            afe_comp_start <= 1'b1;
                            comp_active_q <= 1'b1;
                            state_q <= ST_COMP;
                        end else begin
                            adc_req <= 1'b1;
                            state_q <= ST_CONV;
                        end
                    end
                end
                ST_COMP: begin
                    if (afe_comp_done) begin
                        comp_active_q <= 1'b0;
                        first_sample_q <= 1'b1;
                        comp_prd_cnt_q <= 8'h00;
                        stuck_cnt_q <= 8'h00;
                        adc_req <= 1'b1;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (adc_grant && adc_done) begin
                        raw_cap_sample <= adc_data;
                        adc_req <= 1'b0;
                        state_q <= ST_USEF;
                    end
                end
                ST_USEF: begin
                    filtered_cap_value <= first_sample_q ? raw_cap_sample : useful_next;
                    state_q <= ST_AVG;
                end
                ST_AVG: begin
                    if (first_sample_q) begin
                        environment_average <= filtered_cap_value;
                        avg_at_comp_q <= filtered_cap_value;
                    end else if (!near_flag) begin
                        environment_average <= avg_next;
                    end
                    state_q <= ST_DIFF;
                end
                ST_DIFF: begin
                    user_cap_difference <= {1'b0, filtered_cap_value}
                        - {1'b0, environment_average};
                    state_q <= ST_FLAG;
                end
                ST_FLAG: begin
                    near_flag <= !user_cap_difference[12]
                        && (user_cap_difference[11:0] > near_threshold);
                    first_sample_q <= 1'b0;
                    comp_prd_cnt_q <= prd_req ? 8'h00 : comp_prd_cnt_q + 8'h01;
                    stuck_cnt_q <= near_flag ? stuck_cnt_q + 8'h01 : 8'h00;
                    state_q <= ST_IDLE;
                end
                default: begin
                    adc_req <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // prx_proximity

// File: testbench/prx_proximity_asserts.sv
// checker for the proximity unit ports
// assumes bind onto prx_proximity, one clock core_clk, async rst
`timescale 1ns/1ps
module prx_proximity_asserts #(
    parameter SCAN_UNIT_CYC = 5000
) (
    input wire core_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire adc_req,
    input wire adc_grant,
    input wire adc_done,
    input wire afe_comp_start,
    input wire afe_comp_done,
    input wire sensor_pin_select,
    input wire shield_pin_select,
    input wire gain_boost_option,
    input wire high_immunity_option,
    input wire near_flag
);
    // ****
    // helper logic
    // ****
    wire ctrl_wr;
    reg comp_wait_q;
    reg [3:0] samp_cnt_q;
    assign ctrl_wr = psel && penable && pready && pwrite && !pslverr && paddr == 12'h000;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            comp_wait_q <= 1'b0;
            samp_cnt_q <= 4'hF;
        end else begin
            if (afe_comp_start)
                comp_wait_q <= 1'b1;
            else if (afe_comp_done)
                comp_wait_q <= 1'b0;
            if (adc_grant && adc_done)
                samp_cnt_q <= 4'h0;
            else if (samp_cnt_q != 4'hF)
                samp_cnt_q <= samp_cnt_q + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("pslverr without pready or with data");
    a_adc_req_held: assert property (adc_req && !(adc_grant && adc_done) |=> adc_req)
        else $error("converter request dropped early");
    a_adc_req_drop: assert property (adc_req && adc_grant && adc_done |=> !adc_req)
        else $error("converter request kept after sample");
    a_comp_pulse_only: assert property (afe_comp_start |-> !adc_req ##1 !afe_comp_start)
        else $error("compensation start not a lone pulse");
    a_no_sample_in_comp: assert property (comp_wait_q |-> !adc_req)
        else $error("sample requested during compensation");
    a_pins_follow: assert property (ctrl_wr |-> ##2 sensor_pin_select == $past(pwdata[16], 2)
        && shield_pin_select == $past(pwdata[17], 2))
        else $error("pin selects do not follow control write");
    a_options_follow: assert property (ctrl_wr |-> ##2 gain_boost_option == $past(pwdata[18], 2)
        && high_immunity_option == $past(pwdata[19], 2))
        else $error("options do not follow control write");
    a_near_after_sample: assert property ($changed(near_flag) |-> samp_cnt_q < 4'h9)
        else $error("near flag changed outside a sample");
endmodule // prx_proximity_asserts

bind prx_proximity prx_proximity_asserts #(.SCAN_UNIT_CYC(SCAN_UNIT_CYC)) u_prx_proximity_asserts (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .adc_req, .adc_grant, .adc_done, .afe_comp_start, .afe_comp_done, .sensor_pin_select,
    .shield_pin_select, .gain_boost_option, .high_immunity_option, .near_flag);

// File: testbench/prx_afe_model.sv
// converter, arbiter and front-end model seen by the proximity unit
// assumes core_clk domain; latency set by the bench
`timescale 1ns/1ps
module prx_afe_model (
    input wire core_clk,
    input wire rst,
    input wire adc_req,
    output reg adc_grant,
    output reg adc_done,
    output reg [11:0] adc_data,
    input wire afe_comp_start,
    output reg afe_comp_done,
    input wire [11:0] sample_val,
    input wire [3:0] lat
);
    // ****
    // converter and compensation
    // ****
    reg [3:0] cnt_q;
    reg [3:0] ccnt_q;
    reg cbusy_q;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            adc_grant <= 1'b0;
            adc_done <= 1'b0;
            adc_data <= 12'h5A5;
            afe_comp_done <= 1'b0;
            cnt_q <= 4'h0;
            ccnt_q <= 4'h0;
            cbusy_q <= 1'b0;
        end else begin
            adc_done <= 1'b0;
            afe_comp_done <= 1'b0;
            if (adc_req && !adc_done) begin
                adc_grant <= 1'b1;
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == lat) begin
                    adc_done <= 1'b1;
                    adc_data <= sample_val;
                    cnt_q <= 4'h0;
                end
            end else begin
                adc_grant <= 1'b0;
                cnt_q <= 4'h0;
                adc_data <= ~adc_data;
            end
            if (afe_comp_start) begin
                cbusy_q <= 1'b1;
                ccnt_q <= 4'h0;
            end else if (cbusy_q) begin
                ccnt_q <= ccnt_q + 4'h1;
                if (ccnt_q == 4'h6) begin
                    afe_comp_done <= 1'b1;
                    cbusy_q <= 1'b0;
                end
            end
        end
    end
endmodule // prx_afe_model

// File: testbench/prx_proximity_test.sv
// self-checking bench for the proximity unit
// assumes prx_proximity with short scan unit and prx_afe_model
`timescale 1ns/1ps
module prx_proximity_test;
    // ****
    // signals and helpers
    // ****
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg [11:0] sample_val = 12'h100;
    reg [3:0] lat = 4'h3;
    wire [31:0] prdata;
    wire pready, pslverr, adc_req, adc_grant, adc_done, afe_comp_start, afe_comp_done;
    wire sensor_pin_select, shield_pin_select, gain_boost_option, high_immunity_option;
    wire near_flag;
    wire [11:0] adc_data;
    wire [3:0] sense_gain_setting, sense_frequency_setting;
    integer num_errors = 0;
    integer comparisons = 0;
    integer comp_cnt = 0;
    integer c0;
    reg [31:0] rd;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (afe_comp_start === 1'b1) comp_cnt <= comp_cnt + 1;
    prx_proximity #(.SCAN_UNIT_CYC(4)) u_prx_proximity (.core_clk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .adc_req, .adc_grant, .adc_done,
        .adc_data, .afe_comp_start, .afe_comp_done, .sensor_pin_select, .shield_pin_select,
        .gain_boost_option, .high_immunity_option, .sense_gain_setting,
        .sense_frequency_setting, .near_flag);
    prx_afe_model u_prx_afe_model (.core_clk, .rst, .adc_req, .adc_grant, .adc_done,
        .adc_data, .afe_comp_start, .afe_comp_done, .sample_val, .lat);
    task chk(input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t exp %h got %h", $time, e, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            while (pready !== 1'b1) begin
                @(posedge core_clk);
            end
            rd = pslverr ? 32'hEEEEEEEE : prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task rdc(input [11:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h00000000);
            chk(e, rd);
        end
    endtask
    task ws;
        begin
            while (!(adc_grant === 1'b1 && adc_done === 1'b1)) begin
                @(posedge core_clk);
            end
            repeat (8) @(posedge core_clk);
        end
    endtask
    // ****
    // scenarios
    // ****
    task t_reset;
        begin
            rdc(12'h000, 32'h00000000);
            rdc(12'h004, 32'h00000000);
            rdc(12'h008, 32'h01000044);
            rdc(12'h00C, 32'h00000000);
            rdc(12'h010, 32'h00000000);
            rdc(12'h030, 32'hEEEEEEEE);
            $display("test reset done");
        end
    endtask
    task t_pins;
        begin
            apb(1'b1, 12'h000, 32'h000F0000);
            apb(1'b1, 12'h004, 32'h000000F1);
            @(posedge core_clk);
            chk(32'h0000F1F, {sense_frequency_setting, sense_gain_setting, high_immunity_option,
                gain_boost_option, shield_pin_select, sensor_pin_select});
            apb(1'b1, 12'h000, 32'h00000000);
            @(posedge core_clk);
            chk(32'h0, {shield_pin_select, sensor_pin_select});
            $display("test pins done");
        end
    endtask
    task t_chain;
        begin
            apb(1'b1, 12'h008, 32'h008000F0);
            c0 = comp_cnt;
            apb(1'b1, 12'h000, 32'h00000010);
            ws;
            chk(32'h1, comp_cnt - c0);
            sample_val <= 12'h200;
            rdc(12'h010, 32'h00000000);
            rdc(12'h014, 32'h00000100);
            rdc(12'h01C, 32'h00000100);
            rdc(12'h020, 32'h00000000);
            ws;
            rdc(12'h018, 32'h00000200);
            rdc(12'h01C, 32'h00000110);
            rdc(12'h020, 32'h000000F0);
            rdc(12'h010, 32'h00000001);
            chk(32'h1, near_flag);
            ws;
            sample_val <= 12'h100;
            rdc(12'h01C, 32'h00000110);
            ws;
            rdc(12'h020, 32'hFFFFFFF0);
            rdc(12'h010, 32'h00000000);
            $display("test chain done");
        end
    endtask
    task t_host;
        begin
            lat <= 4'hC;
            ws;
            c0 = comp_cnt;
            apb(1'b1, 12'h024, 32'h00000001);
            apb(1'b0, 12'h010, 32'h00000000);
            chk(32'h2, rd & 32'h2);
            apb(1'b1, 12'h024, 32'h00000001);
            chk(32'h0, comp_cnt - c0);
            ws;
            chk(32'h1, comp_cnt - c0);
            apb(1'b0, 12'h010, 32'h00000000);
            chk(32'h0, rd & 32'h2);
            $display("test host done");
        end
    endtask
    task t_auto;
        begin
            c0 = comp_cnt;
            apb(1'b1, 12'h00C, 32'h00002000);
            repeat (6) ws;
            chk(32'h1, comp_cnt - c0 >= 2);
            apb(1'b1, 12'h00C, 32'h00200000);
            repeat (2) ws;
            sample_val <= 12'h300;
            c0 = comp_cnt;
            repeat (5) ws;
            chk(32'h1, comp_cnt - c0 >= 1);
            apb(1'b1, 12'h00C, 32'h00000001);
            sample_val <= 12'h380;
            c0 = comp_cnt;
            repeat (4) ws;
            chk(32'h1, comp_cnt - c0 >= 1);
            $display("test auto done");
        end
    endtask
    task t_off;
        integer n;
        begin
            apb(1'b1, 12'h000, 32'h00000000);
            repeat (30) @(posedge core_clk);
            n = 0;
            c0 = comp_cnt;
            repeat (300) begin
                @(posedge core_clk);
                if (adc_req !== 1'b0) n = n + 1;
            end
            chk(32'h0, n + comp_cnt - c0);
            $display("test off done");
        end
    endtask
    task stop_test;
        begin
            $display("errors %0d comparisons %0d", num_errors, comparisons);
            if (num_errors == 0 && comparisons > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        #400000;
        num_errors = num_errors + 1;
        stop_test;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset;
        t_pins;
        t_chain;
        t_host;
        t_auto;
        t_off;
        stop_test;
    end
endmodule // prx_proximity_test
